// file: verilog/pcl_link.sv
`timescale 1ns/1ps
module pcl_link
  import pcl_pkg::*;
#(
  parameter int BIT_LEN  = BIT_CYC,
  parameter int RESP_LEN = RESP_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [4:0]  dev_addr,
  input  wire logic        rxd,
  output logic             txd,
  output logic             txd_oe,
  output logic             cmd_valid,
  input  wire logic        cmd_ready,
  output logic [13:0]      cmd_name,
  output logic [31:0]      cmd_value,
  output logic             cmd_has_value,
  output logic             exec_go,
  input  wire logic        resp_valid,
  input  wire logic        resp_ok,
  input  wire logic        resp_has_data,
  input  wire logic [7:0]  resp_data,
  output logic             selected,
  output logic             group_mode,
  output logic             group_poll_en,
  output logic             motion_abort,
  output logic             ref_lost
);
  localparam int TW = $clog2(RESP_LEN + 1);
  localparam logic [TW-1:0] TMO_LAST = TW'(RESP_LEN - 1);

  typedef enum logic [3:0] {
    ST_IDLE, ST_POLL, ST_SCAN, ST_EMIT, ST_WAIT,
    ST_ACK, ST_HI, ST_LO, ST_CR, ST_ECHO
  } pcl_state_t;

  pcl_state_t        st_q;
  logic [6:0]        buf_q [REC_MAX];
  logic [LEN_W-1:0]  len_q;
  logic [LEN_W-1:0]  slen_q;
  logic [LEN_W-1:0]  idx_q;
  logic              bad_q;
  logic [1:0]        pass_q;
  logic              in_tok_q;
  logic [13:0]       name_q;
  logic              nlen2_q;
  logic              eq_q;
  logic              neg_q;
  logic              hv_q;
  logic [31:0]       val_q;
  logic              ok_q;
  logic              hasd_q;
  logic [7:0]        data_q;
  logic [6:0]        echo_q;
  logic              sel_q;
  logic              grp_q;
  logic              ga_en_q;
  logic [TW-1:0]     tmo_q;
  logic              tx_start;
  logic [6:0]        tx_data;
  logic              tx_busy;
  logic              rx_valid;
  logic [6:0]        rx_data;
  logic              rx_perr;
  logic              rx_break;
  logic [6:0]        ch;
  logic              is_end;
  logic              is_sep;
  logic              is_let;
  logic              is_sign;
  logic              fin;
  logic              syn_err;
  logic              ga_wr;
  logic              tmo_hit;
  logic              poll_ok;
  logic [6:0]        paddr;

  pcl_uart #(.BIT_LEN(BIT_LEN)) u_uart (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .rxd      (rxd),
    .txd      (txd),
    .tx_start (tx_start),
    .tx_data  (tx_data),
    .tx_busy  (tx_busy),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .rx_perr  (rx_perr),
    .rx_break (rx_break)
  );

  // character error drops the record silently
  always_ff @(posedge clk_sys) begin
    if (rst || rx_break || rx_perr) begin
      len_q <= '0;
      bad_q <= 1'b0;
    end else if (st_q == ST_IDLE && rx_valid) begin
      if (rx_data == CH_CR || rx_data == CH_CAN) begin
        len_q <= '0;
        bad_q <= 1'b0;
      end else if (rx_data == CH_DEL || rx_data == CH_BS) begin
        if (len_q != '0) len_q <= len_q - 1'b1;
      end else if (len_q < LEN_W'(REC_MAX)) begin
        buf_q[len_q] <= rx_data;
        len_q        <= len_q + 1'b1;
      end else begin
        bad_q <= 1'b1;
      end
    end
  end

  // poll string: hash, one or two digits
  always_comb begin
    // tens digit widened first so addresses above 15 survive
    paddr   = (slen_q == LEN_W'(2)) ? {3'h0, buf_q[1][3:0]} :
              7'({3'h0, buf_q[1][3:0]} * 7'h0A + {3'h0, buf_q[2][3:0]});
    poll_ok = ((slen_q == LEN_W'(2) && is_digit(buf_q[1])) ||
               (slen_q == LEN_W'(3) && is_digit(buf_q[1]) &&
                is_digit(buf_q[2]))) && paddr <= 7'(ADDR_MAX);
  end

  // selection follows polls, errors and break
  always_ff @(posedge clk_sys) begin
    if (rst || rx_break || rx_perr) begin
      sel_q <= 1'b0;
      grp_q <= 1'b0;
    end else if (st_q == ST_POLL) begin
      sel_q <= poll_ok && paddr != 7'h00 && paddr == {2'h0, dev_addr};
      // address zero only when group poll enabled
      grp_q <= poll_ok && paddr == 7'h00 && ga_en_q;
    end
  end

  // group poll enable, cleared at reset
  always_ff @(posedge clk_sys) begin
    if (rst) ga_en_q <= 1'b0;
    else if (ga_wr) ga_en_q <= val_q != 32'h0;
  end

  // break stops motion and drops the reference
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      motion_abort <= 1'b0;
      ref_lost     <= 1'b0;
    end else begin
      motion_abort <= rx_break;
      ref_lost     <= rx_break;
    end
  end

  // reply timer from the closing return
  always_ff @(posedge clk_sys) begin
    if (rst || st_q == ST_IDLE) tmo_q <= '0;
    else if (tmo_q != TMO_LAST) tmo_q <= tmo_q + 1'b1;
  end
  assign tmo_hit = tmo_q == TMO_LAST;

  always_comb begin
    is_end  = idx_q >= slen_q;
    ch      = is_end ? CH_CR : buf_q[idx_q];
    is_sep  = ch == CH_SP || ch == CH_TAB || ch == CH_COMMA || ch == CH_LF;
    is_let  = ch >= 7'h41 && ch <= 7'h5A;
    is_sign = ch == CH_MINUS || ch == CH_PLUS;
    fin     = in_tok_q && (is_end || is_sep || (is_let && (hv_q || eq_q)));
    syn_err = !fin && ((is_let && in_tok_q && nlen2_q) ||
              (is_digit(ch) && !in_tok_q) ||
              (ch == CH_EQ && !(in_tok_q && !eq_q && !hv_q)) ||
              (is_sign && !(in_tok_q && !hv_q)) ||
              !(is_let || is_digit(ch) || is_sep || is_end ||
                ch == CH_EQ || is_sign));
    ga_wr   = st_q == ST_SCAN && !tmo_hit && fin &&
              pass_q == PASS_PARAM && name_q == NM_GRP;
  end

  // record processing and reply sequencing
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q          <= ST_IDLE;
      slen_q        <= '0;
      idx_q         <= '0;
      pass_q        <= PASS_SAVE;
      in_tok_q      <= 1'b0;
      name_q        <= 14'h0000;
      nlen2_q       <= 1'b0;
      eq_q          <= 1'b0;
      neg_q         <= 1'b0;
      hv_q          <= 1'b0;
      val_q         <= 32'h0;
      cmd_name      <= 14'h0000;
      cmd_value     <= 32'h0;
      cmd_has_value <= 1'b0;
      exec_go       <= 1'b0;
      ok_q          <= 1'b0;
      hasd_q        <= 1'b0;
      data_q        <= 8'h00;
      echo_q        <= 7'h00;
    end else begin
      exec_go <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (rx_valid && rx_data == CH_CR) begin
            slen_q   <= len_q;
            idx_q    <= '0;
            pass_q   <= PASS_SAVE;
            in_tok_q <= 1'b0;
            ok_q     <= 1'b0;
            hasd_q   <= 1'b0;
            if (len_q != '0 && buf_q[0] == CH_HASH) st_q <= ST_POLL;
            else if ((sel_q || grp_q) && bad_q) st_q <= ST_ACK;
            else if (sel_q || grp_q) st_q <= ST_SCAN;
          end else if (rx_valid && rx_data == CH_DEL && len_q != '0 &&
                       sel_q) begin
            echo_q <= buf_q[len_q - 1'b1];
            st_q   <= ST_ECHO;
          end
        end
        ST_POLL: st_q <= ST_IDLE;
        ST_SCAN: begin
          if (tmo_hit || syn_err) begin
            ok_q <= 1'b0;
            st_q <= ST_ACK;
          end else if (fin) begin
            in_tok_q <= 1'b0;
            // hand out only this pass's class
            // repeats handed out in order, last wins
            if (cmd_class(name_q) == pass_q && name_q != NM_GRP) begin
              cmd_name      <= name_q;
              cmd_value     <= neg_q ? 32'h0 - val_q : val_q;
              cmd_has_value <= hv_q;
              st_q          <= ST_EMIT;
            end
          end else if (is_end) begin
            idx_q <= '0;
            if (pass_q == PASS_ACT) begin
              exec_go <= 1'b1;
              st_q    <= ST_WAIT;
            end else begin
              pass_q <= pass_q + 1'b1;
            end
          end else begin
            idx_q <= idx_q + 1'b1;
            if (is_let && !in_tok_q) begin
              in_tok_q <= 1'b1;
              name_q   <= {7'h00, ch};
              nlen2_q  <= 1'b0;
              eq_q     <= 1'b0;
              neg_q    <= 1'b0;
              hv_q     <= 1'b0;
              val_q    <= 32'h0;
            end else if (is_let) begin
              name_q  <= {name_q[6:0], ch};
              nlen2_q <= 1'b1;
            end else if (is_digit(ch)) begin
              val_q <= {val_q[28:0], 3'h0} + {val_q[30:0], 1'b0} +
                       {28'h0, ch[3:0]};
              hv_q  <= 1'b1;
            end else if (ch == CH_EQ) begin
              eq_q <= 1'b1;
            end else if (ch == CH_MINUS) begin
              neg_q <= 1'b1;
            end
          end
        end
        ST_EMIT: begin
          if (cmd_ready) st_q <= ST_SCAN;
          else if (tmo_hit) st_q <= ST_ACK;
        end
        ST_WAIT: begin
          if (resp_valid) begin
            ok_q   <= resp_ok;
            hasd_q <= resp_has_data;
            data_q <= resp_data;
            st_q   <= ST_ACK;
          end else if (tmo_hit) begin
            ok_q <= 1'b0;
            st_q <= ST_ACK;
          end
        end
        ST_ACK, ST_HI, ST_LO, ST_CR, ST_ECHO: begin
          // group selected: executed, no answer sent
          if (!sel_q) begin
            st_q <= ST_IDLE;
          end else if (!tx_busy) begin
            case (st_q)
              ST_ACK:  st_q <= (ok_q && hasd_q) ? ST_HI : ST_CR;
              ST_HI:   st_q <= ST_LO;
              ST_LO:   st_q <= ST_CR;
              default: st_q <= ST_IDLE;
            endcase
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign tx_start = sel_q && !tx_busy &&
                    (st_q == ST_ACK || st_q == ST_HI || st_q == ST_LO ||
                     st_q == ST_CR || st_q == ST_ECHO);

  always_comb begin
    case (st_q)
      ST_ACK:  tx_data = ok_q ? CH_ACK : CH_NAK;
      ST_HI:   tx_data = nib2asc(data_q[7:4]);
      ST_LO:   tx_data = nib2asc(data_q[3:0]);
      ST_ECHO: tx_data = echo_q;
      default: tx_data = CH_CR;
    endcase
  end

  assign txd_oe        = tx_busy;
  assign cmd_valid     = st_q == ST_EMIT;
  assign selected      = sel_q;
  assign group_mode    = grp_q;
  assign group_poll_en = ga_en_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_del_taken;
    st_q == ST_IDLE && rx_valid && rx_data == CH_DEL && len_q != '0 && sel_q;
  endsequence
  sequence s_data_ack;
    st_q == ST_ACK && tx_start && ok_q && hasd_q;
  endsequence

  a_tx_when_sel: assert property ($rose(txd_oe) |-> $past(sel_q))
    else $error("line driven while not selected");
  a_break_abort: assert property (rx_break |=>
    motion_abort && ref_lost && !sel_q && !grp_q)
    else $error("break did not abort and deselect");
  a_err_desel: assert property (rx_perr |=> !sel_q && !grp_q)
    else $error("character error left device selected");
  a_grp_reset: assert property (disable iff (1'b0)
    rst |=> !ga_en_q)
    else $error("group poll enable not cleared");
  a_poll_quiet: assert property (st_q == ST_POLL |=>
    st_q == ST_IDLE && !tx_start)
    else $error("poll order answered");
  a_pass_order: assert property (cmd_valid |->
    cmd_class(cmd_name) == pass_q && $stable(pass_q))
    else $error("instruction handed out in wrong pass");
  a_del_echo: assert property (s_del_taken |=>
    st_q == ST_ECHO && len_q == $past(len_q) - 1'b1)
    else $error("delete not echoed");
  a_hex_first: assert property (s_data_ack |=> st_q == ST_HI)
    else $error("data not sent high nibble first");
  a_nak_syntax: assert property (st_q == ST_SCAN && syn_err
    |=> st_q == ST_ACK && !ok_q)
    else $error("bad record not answered with nak");
  a_reply_bound: assert property ((st_q == ST_WAIT ||
    st_q == ST_EMIT) && tmo_hit |=> st_q == ST_ACK || st_q == ST_SCAN)
    else $error("reply deadline missed");
  a_grp_silent: assert property (grp_q |-> !tx_start)
    else $error("group selected device transmitted");
endmodule : pcl_link

// file: verilog/pcl_pkg.sv
package pcl_pkg;
  // clock and line timing
  localparam int CLK_HZ    = 100_000_000;
  localparam int BAUD      = 9600;
  localparam int BIT_CYC   = CLK_HZ / BAUD;
  localparam int RESP_MS   = 200;
  localparam int RESP_CYC  = RESP_MS * (CLK_HZ / 1000);
  // record limits
  localparam int REC_MAX   = 80;
  localparam int LEN_W     = 7;
  localparam int ADDR_MAX  = 31;
  localparam int CHAR_W    = 7;
  // control and syntax characters
  localparam logic [6:0] CH_CR    = 7'h0D;
  localparam logic [6:0] CH_LF    = 7'h0A;
  localparam logic [6:0] CH_ACK   = 7'h06;
  localparam logic [6:0] CH_NAK   = 7'h15;
  localparam logic [6:0] CH_DEL   = 7'h7F;
  localparam logic [6:0] CH_BS    = 7'h08;
  localparam logic [6:0] CH_CAN   = 7'h18;
  localparam logic [6:0] CH_HASH  = 7'h23;
  localparam logic [6:0] CH_SP    = 7'h20;
  localparam logic [6:0] CH_TAB   = 7'h09;
  localparam logic [6:0] CH_COMMA = 7'h2C;
  localparam logic [6:0] CH_EQ    = 7'h3D;
  localparam logic [6:0] CH_MINUS = 7'h2D;
  localparam logic [6:0] CH_PLUS  = 7'h2B;
  // instruction names, one or two 7-bit letters, first letter high, upper letter zero for one-letter names
  localparam logic [13:0] NM_SAVE = {7'h53, 7'h56};
  localparam logic [13:0] NM_LOAD = {7'h52, 7'h44};
  localparam logic [13:0] NM_GRP  = {7'h42, 7'h41};
  localparam logic [13:0] NM_MOVE = {7'h00, 7'h58};
  localparam logic [13:0] NM_EXEC = {7'h00, 7'h45};
  // processing passes over one record
  localparam logic [1:0] PASS_SAVE  = 2'h0;
  localparam logic [1:0] PASS_LOAD  = 2'h1;
  localparam logic [1:0] PASS_PARAM = 2'h2;
  localparam logic [1:0] PASS_ACT   = 2'h3;

  // pass in which an instruction is handed out
  function automatic logic [1:0] cmd_class(input logic [13:0] nm);
    if (nm == NM_SAVE) return PASS_SAVE;
    if (nm == NM_LOAD) return PASS_LOAD;
    if (nm == NM_MOVE || nm == NM_EXEC) return PASS_ACT;
    return PASS_PARAM;
  endfunction : cmd_class

  function automatic logic is_digit(input logic [6:0] c);
    return c >= 7'h30 && c <= 7'h39;
  endfunction : is_digit

  // nibble to ascii hex digit
  function automatic logic [6:0] nib2asc(input logic [3:0] n);
    return (n < 4'hA) ? {3'h3, n} : 7'(7'h37 + {3'h0, n});
  endfunction : nib2asc
endpackage : pcl_pkg

// file: verilog/pcl_uart.sv
`timescale 1ns/1ps
module pcl_uart
  import pcl_pkg::*;
#(
  parameter int BIT_LEN = BIT_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       rxd,
  output logic            txd,
  input  wire logic       tx_start,
  input  wire logic [6:0] tx_data,
  output logic            tx_busy,
  output logic            rx_valid,
  output logic [6:0]      rx_data,
  output logic            rx_perr,
  output logic            rx_break
);
  localparam int CW = $clog2(BIT_LEN + 1);
  localparam logic [CW-1:0] FULL = CW'(BIT_LEN - 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_LEN / 2);

  typedef enum logic [1:0] {R_IDLE, R_BITS, R_WAITHI} pcl_rx_state_t;

  pcl_rx_state_t   rst_q;
  logic [CW-1:0]   rcnt_q;
  logic [3:0]      rbit_q;
  logic [7:0]      rsh_q;
  logic [CW-1:0]   tcnt_q;
  logic [3:0]      tbit_q;
  logic [9:0]      tsh_q;

  // receiver: start, 7 data, even parity, 1 stop, sampled mid bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rst_q    <= R_IDLE;
      rcnt_q   <= '0;
      rbit_q   <= 4'h0;
      rsh_q    <= 8'h00;
      rx_valid <= 1'b0;
      rx_data  <= 7'h00;
      rx_perr  <= 1'b0;
      rx_break <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      rx_perr  <= 1'b0;
      rx_break <= 1'b0;
      case (rst_q)
        R_IDLE: begin
          if (!rxd) begin
            rcnt_q <= HALF;
            rbit_q <= 4'h0;
            rst_q  <= R_BITS;
          end
        end
        R_BITS: begin
          if (rcnt_q != '0) begin
            rcnt_q <= rcnt_q - 1'b1;
          end else begin
            rcnt_q <= FULL;
            if (rbit_q == 4'h9) begin
              rst_q <= rxd ? R_IDLE : R_WAITHI;
              if (rsh_q == 8'h00 && !rxd) begin
                rx_break <= 1'b1;
              end else if (!rxd || ^rsh_q) begin
                rx_perr <= 1'b1;
              end else begin
                rx_valid <= 1'b1;
                rx_data  <= rsh_q[6:0];
              end
            end else begin
              if (rbit_q != 4'h0) begin
                rsh_q <= {rxd, rsh_q[7:1]};
              end
              rbit_q <= rbit_q + 1'b1;
            end
          end
        end
        R_WAITHI: begin
          if (rxd) begin
            rst_q <= R_IDLE;
          end
        end
        default: rst_q <= R_IDLE;
      endcase
    end
  end

  // transmitter, frame shifted out lsb first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tsh_q   <= 10'h3FF;
      tcnt_q  <= '0;
      tbit_q  <= 4'h0;
      tx_busy <= 1'b0;
    end else if (!tx_busy) begin
      if (tx_start) begin
        tsh_q   <= {1'b1, ^tx_data, tx_data, 1'b0};
        tcnt_q  <= FULL;
        tbit_q  <= 4'h0;
        tx_busy <= 1'b1;
      end
    end else if (tcnt_q != '0) begin
      tcnt_q <= tcnt_q - 1'b1;
    end else begin
      tcnt_q <= FULL;
      tsh_q  <= {1'b1, tsh_q[9:1]};
      if (tbit_q == 4'h9) begin
        tx_busy <= 1'b0;
      end else begin
        tbit_q <= tbit_q + 1'b1;
      end
    end
  end

  assign txd = tsh_q[0];
endmodule : pcl_uart

// file: tb/pcl_host.sv
`timescale 1ns/1ps
// host master model: frames records onto rxd, decodes replies on txd
module pcl_host #(
  parameter int BIT_LEN = 16
) (
  input  wire logic       clk_sys,
  input  wire logic       txd,
  output logic            rxd,
  output logic            got,
  output logic [6:0]      got_char
);
  logic [9:0] sh;

  // line idles high between frames
  initial begin
    rxd = 1'b1;
    got = 1'b0;
    got_char = 7'h00;
  end

  task automatic send_char(input logic [6:0] c, input logic bad);
    logic [9:0] f;
    f = {1'b1, ^c ^ bad, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_sys) rxd = f[i];
      repeat (BIT_LEN - 1) @(negedge clk_sys);
    end
  endtask : send_char

  // line held low well past one frame
  task automatic send_break();
    @(negedge clk_sys) rxd = 1'b0;
    repeat (12 * BIT_LEN) @(negedge clk_sys);
    rxd = 1'b1;
    repeat (4 * BIT_LEN) @(negedge clk_sys);
  endtask : send_break

  // decode replies; a bad frame shows as 00h
  always begin
    @(negedge txd);
    repeat (BIT_LEN / 2) @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      if (i > 0) repeat (BIT_LEN) @(posedge clk_sys);
      sh[i] = txd;
    end
    got_char = (!sh[0] && sh[9] && !(^sh[8:1])) ? sh[7:1] : 7'h00;
    got = 1'b1;
    @(posedge clk_sys) got = 1'b0;
  end
endmodule : pcl_host

// file: tb/pcl_link_tb.sv
`timescale 1ns/1ps
// polled link bench: host model on the line, user side driven here
module pcl_link_tb
  import pcl_pkg::*;
();
  localparam int BL = 16;
  localparam logic [13:0] NM_WIN = {7'h50, 7'h57};
  logic        clk_sys, rst, rxd, txd, cmd_valid, cmd_ready, exec_go;
  logic        resp_valid, resp_ok, resp_has_data, selected, group_mode;
  logic        group_poll_en, motion_abort, ref_lost, got, r_ok, r_hd, r_skip;
  logic        txd_oe, cmd_has_value;
  logic [6:0]  got_char;
  logic [7:0]  resp_data, r_data;
  logic [13:0] cmd_name;
  logic [31:0] cmd_value;
  logic [6:0]  exp_tx[$];
  logic [45:0] exp_cmd[$];
  integer      err_count, cmp_count, seed, brk_n;

  pcl_link #(.BIT_LEN(BL), .RESP_LEN(2000)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .dev_addr(5'h0E), .rxd(rxd), .txd(txd),
    .txd_oe(txd_oe), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_name(cmd_name), .cmd_value(cmd_value),
    .cmd_has_value(cmd_has_value),
    .exec_go(exec_go), .resp_valid(resp_valid), .resp_ok(resp_ok),
    .resp_has_data(resp_has_data), .resp_data(resp_data),
    .selected(selected), .group_mode(group_mode),
    .group_poll_en(group_poll_en), .motion_abort(motion_abort),
    .ref_lost(ref_lost));
  pcl_host #(.BIT_LEN(BL)) host_u (
    .clk_sys(clk_sys), .txd(txd), .rxd(rxd), .got(got), .got_char(got_char));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [45:0] e,
                     input logic [45:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic close_out();
    if (err_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  // records stay far below 80 characters
  // at most one data query per record
  task automatic rec(input string s);
    for (int i = 0; i < s.len(); i++) host_u.send_char(7'(s[i]), 1'b0);
    host_u.send_char(CH_CR, 1'b0);
  endtask : rec

  function automatic logic [6:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? 7'h30 + 7'(n) : 7'h37 + 7'(n);
  endfunction : hexc

  // notes the reply and the result the user will give
  task automatic answer(input logic ok, input logic hd, input logic [7:0] d);
    r_ok = ok;
    r_hd = hd;
    r_data = d;
    exp_tx.push_back(ok ? CH_ACK : CH_NAK);
    if (ok && hd) begin
      exp_tx.push_back(hexc(d[7:4]));
      exp_tx.push_back(hexc(d[3:0]));
    end
    exp_tx.push_back(CH_CR);
  endtask : answer

  task automatic want(input logic [13:0] n, input logic [31:0] v);
    exp_cmd.push_back({n, v});
  endtask : want

  // wait for the notes to be used up, then watch for strays
  task automatic drain();
    for (int i = 0; i < 8000; i++) begin
      if (exp_tx.size() == 0 && exp_cmd.size() == 0) break;
      @(negedge clk_sys);
    end
    repeat (2500) @(negedge clk_sys);
    chk("tx_left", 46'h0, 46'(exp_tx.size()));
    chk("cmd_left", 46'h0, 46'(exp_cmd.size()));
  endtask : drain

  // reply characters against the oldest note
  always @(posedge got) begin
    chk("tx_char", exp_tx.size() ? 46'(exp_tx.pop_front()) : 46'bx,
        46'(got_char));
    chk("txd_oe", 46'h1, 46'(txd_oe));
  end

  // instruction hand-out and break pulses
  always @(posedge clk_sys) begin
    if (cmd_valid && cmd_ready) begin
      chk("cmd", exp_cmd.size() ? exp_cmd.pop_front() : 46'bx,
          {cmd_name, cmd_value});
      chk("has_value", 46'h1, 46'(cmd_has_value));
    end
    if (motion_abort === 1'b1) begin
      brk_n++;
      chk("ref_lost", 46'h1, 46'(ref_lost));
    end
  end

  // user stalls the hand-out at random
  always @(negedge clk_sys) cmd_ready = 1'($random(seed));

  // user answers each finished record one cycle later, unless r_skip is set
  always @(posedge clk_sys) begin
    if (exec_go === 1'b1 && !r_skip) begin
      @(negedge clk_sys);
      resp_ok = r_ok;
      resp_has_data = r_hd;
      resp_data = r_data;
      resp_valid = 1'b1;
      @(negedge clk_sys) resp_valid = 1'b0;
    end
  end

  initial begin
    repeat (90000) @(posedge clk_sys);
    err_count++;
    close_out();
  end

  initial begin
    seed = 67;
    rst = 1'b1;
    cmd_ready = 1'b0;
    resp_valid = 1'b0;
    resp_ok = 1'b0;
    resp_has_data = 1'b0;
    resp_data = 8'h00;
    r_skip = 1'b0;
    err_count = 0;
    cmp_count = 0;
    brk_n = 0;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    chk("grp_en", 46'h0, 46'(group_poll_en));
    // a poll first; foreign address, then an unpolled record
    rec("#3");
    rec("X1");
    drain();
    chk("sel", 46'h0, 46'(selected));
    rec("#14");
    drain();
    chk("sel", 46'h1, 46'(selected));
    want(NM_SAVE, 0);
    want(NM_LOAD, 2);
    want(NM_WIN, 256);
    want(NM_MOVE, 1000);
    answer(1'b1, 1'b1, 8'($random(seed)));
    rec($sformatf("X1000\tPW=256,RD2 %c%c0", NM_SAVE[13:7], NM_SAVE[6:0]));
    drain();
    want(NM_WIN, 1);
    want(NM_WIN, 7);
    answer(1'b0, 1'b0, 8'h00);
    rec("PW1 PW=7");
    drain();
    answer(1'b0, 1'b0, 8'h00);
    rec("pw1");
    drain();
    // delete echoes, backspace silent, cancel clears
    exp_tx.push_back(7'h32);
    want(NM_WIN, 1);
    answer(1'b1, 1'b0, 8'h00);
    rec("PW12\1779\010");
    drain();
    want(NM_WIN, 4);
    answer(1'b1, 1'b0, 8'h00);
    rec("X5\030PW4");
    drain();
    // silent user: refusal once the time limit runs out
    r_skip = 1'b1;
    want(NM_WIN, 3);
    answer(1'b0, 1'b0, 8'h00);
    rec("PW3");
    drain();
    r_skip = 1'b0;
    host_u.send_char(7'h50, 1'b0);
    host_u.send_char(7'h57, 1'b1);
    host_u.send_char(CH_CR, 1'b0);
    drain();
    chk("sel", 46'h0, 46'(selected));
    rec("#14");
    rec("#0");
    drain();
    chk("sel", 46'h0, 46'(selected));
    chk("grp", 46'h0, 46'(group_mode));
    rec("#14");
    answer(1'b1, 1'b0, 8'h00);
    rec("BA1");
    drain();
    chk("grp_en", 46'h1, 46'(group_poll_en));
    want(NM_WIN, 2);
    rec("#0");
    rec("PW2");
    drain();
    chk("grp", 46'h1, 46'(group_mode));
    host_u.send_break();
    drain();
    chk("abort", 46'h1, 46'(brk_n));
    chk("grp", 46'h0, 46'(group_mode));
    close_out();
  end
endmodule : pcl_link_tb
